// ---- design/ocs_clock_ctrl.sv ----
// Oscillator source select, fast RC postscaler, PLL factor decode and instruction/peripheral clock ticks.
// Assumes oscillator pins slower than pclk/4 and an analog PLL outside that reports its output and lock.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module ocs_clock_ctrl
	import ocs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pce,
	// APB slave
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic            pready,
	output logic            pslverr,
	// Oscillator pins and analog PLL feedback
	input  wire logic       fast_rc_osc_in,
	input  wire logic       primary_osc_in,
	input  wire logic       secondary_crystal_osc_in,
	input  wire logic       low_power_rc_osc_in,
	input  wire logic       pll_clk_in,
	input  wire logic       pll_lock_in,
	// Nonvolatile straps and interrupt wake
	input  wire logic [2:0] initial_source_select,
	input  wire logic [1:0] primary_mode_select,
	input  wire logic       irq_pending,
	// Analog PLL control
	output logic            pll_enable,
	output logic            pll_from_primary,
	output logic [5:0]      pll_n1,
	output logic [9:0]      pll_m,
	output logic [3:0]      pll_n2,
	// Oscillator mode controls
	output logic            crystal_mode_en,
	output logic            high_speed_crystal_mode_en,
	output logic            external_clock_mode_en,
	output logic            secondary_osc_en,
	// Clock ticks
	output logic            fosc_tick,
	output logic            peripheral_clock_tick,
	output logic            cpu_clock_tick,
	output logic            watchdog_timer_ref_tick
);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic [OCS_NUM_OSC-1:0] osc_lvl;
	logic [OCS_NUM_OSC-1:0] osc_rise;
	logic [4:0]             strap_lvl;

	ocs_sync #(.WIDTH(OCS_NUM_OSC)) u_osc_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pce      (pce),
		.async_in ({pll_lock_in, pll_clk_in, low_power_rc_osc_in, secondary_crystal_osc_in,
		            primary_osc_in, fast_rc_osc_in}),
		.sync_out (osc_lvl),
		.rise_out (osc_rise)
	);

	ocs_sync #(.WIDTH(5)) u_strap_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pce      (pce),
		.async_in ({primary_mode_select, initial_source_select}),
		.sync_out (strap_lvl),
		.rise_out ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [2:0]    frcdiv_ff;
	logic [2:0]    doze_ff;
	logic [1:0]    post_ff;
	logic [4:0]    pre_ff;
	logic [8:0]    fb_ff;
	logic          roi_ff;
	logic          dozen_ff;
	logic          switch_req_ff;
	logic [1:0]    strap_cnt_ff;
	ocs_src_t      new_src_ff;
	ocs_pmode_t    pmode_ff;
	ocs_src_t      cur_src_ff;
	ocs_src_t      tgt_src_ff;
	ocs_sw_state_t sw_state_ff;
	logic [3:0]    stable_cnt_ff;
	logic [31:0]   prdata_ff;
	logic [3:0]    mode;

	logic apb_setup;
	logic apb_access;
	logic addr_hit;
	logic wr_en;
	logic strap_take;
	logic strap_done;
	logic sw_done;

	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;
	assign addr_hit   = (paddr == OCS_ADDR_CLOCK_DIVISOR) || (paddr == OCS_ADDR_PLL_FEEDBACK) ||
	                    (paddr == OCS_ADDR_OSC_CONTROL) || (paddr == OCS_ADDR_PLL_FACTOR);
	assign wr_en      = pce && apb_access && pwrite && addr_hit;
	assign strap_take = (strap_cnt_ff == OCS_STRAP_TAKE);
	assign strap_done = (strap_cnt_ff == OCS_STRAP_DONE);
	assign sw_done    = (sw_state_ff == OCS_SW_SWAP);
	assign pready     = 1'b1;
	assign pslverr    = apb_access && !addr_hit;
	assign prdata     = prdata_ff;

	// Straps are read only once the synchroniser has filled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_ff <= 2'h0;
		end else if (pce && !strap_done) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frcdiv_ff <= OCS_RST_FRCDIV;
			doze_ff   <= OCS_RST_DOZE;
			post_ff   <= OCS_RST_POST;
			pre_ff    <= OCS_RST_PRE;
			fb_ff     <= OCS_RST_FB;
			roi_ff    <= 1'b0;
		end else if (wr_en && paddr == OCS_ADDR_CLOCK_DIVISOR) begin
			roi_ff    <= pwdata[OCS_CD_ROI];
			doze_ff   <= pwdata[OCS_CD_DOZE_LSB +: 3];
			frcdiv_ff <= pwdata[OCS_CD_FRCDIV_LSB +: 3];
			post_ff   <= pwdata[OCS_CD_POST_LSB +: 2];
			pre_ff    <= pwdata[OCS_CD_PRE_LSB +: 5];
		end else if (wr_en && paddr == OCS_ADDR_PLL_FEEDBACK) begin
			fb_ff     <= pwdata[8:0];
		end
	end

	// With roi set, an interrupt wins over a write that would set doze in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dozen_ff <= 1'b0;
		end else if (pce && roi_ff && irq_pending) begin
			dozen_ff <= 1'b0;
		end else if (wr_en && paddr == OCS_ADDR_CLOCK_DIVISOR) begin
			dozen_ff <= pwdata[OCS_CD_DOZEN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			new_src_ff <= OCS_SRC_FRC;
			pmode_ff   <= OCS_PM_NONE;
		end else if (pce && strap_take) begin
			new_src_ff <= ocs_src_t'(strap_lvl[2:0]);
			pmode_ff   <= ocs_pmode_t'(strap_lvl[4:3]);
		end else if (wr_en && paddr == OCS_ADDR_OSC_CONTROL) begin
			new_src_ff <= ocs_src_t'(pwdata[OCS_OC_NEW_LSB +: 3]);
		end
	end

	// Software sets the request, the switch clears it; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_req_ff <= 1'b0;
		end else if (wr_en && paddr == OCS_ADDR_OSC_CONTROL && pwdata[OCS_OC_SWITCH]) begin
			switch_req_ff <= 1'b1;
		end else if (pce && sw_done) begin
			switch_req_ff <= 1'b0;
		end
	end

	// Read data is caught in the setup phase so that the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (pce && apb_setup && !pwrite) begin
			prdata_ff <= 32'h0000_0000;
			case (paddr)
				OCS_ADDR_CLOCK_DIVISOR: begin
					prdata_ff <= {16'h0000, roi_ff, doze_ff, dozen_ff, frcdiv_ff, post_ff, 1'b0, pre_ff};
				end
				OCS_ADDR_PLL_FEEDBACK: begin
					prdata_ff <= {23'h000000, fb_ff};
				end
				OCS_ADDR_OSC_CONTROL: begin
					prdata_ff <= {17'h00000, cur_src_ff, 1'b0, new_src_ff, 2'h0, osc_lvl[OCS_IDX_LOCK],
					              4'h0, switch_req_ff};
				end
				OCS_ADDR_PLL_FACTOR: begin
					prdata_ff <= {mode, 2'h0, pll_m, 4'h0, pll_n2, 2'h0, pll_n1};
				end
				default: begin
					prdata_ff <= 32'h0000_0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source decode
	function automatic logic is_pll(input ocs_src_t s);
		return (s == OCS_SRC_FRC_PLL) || (s == OCS_SRC_PRI_PLL);
	endfunction

	function automatic logic is_pri(input ocs_src_t s);
		return (s == OCS_SRC_PRI) || (s == OCS_SRC_PRI_PLL);
	endfunction

	// Raw oscillator edge behind each source, used to judge that it runs
	function automatic logic base_rise(input ocs_src_t s, input logic [OCS_NUM_OSC-1:0] r);
		case (s)
			OCS_SRC_FRC_PLL, OCS_SRC_PRI_PLL: return r[OCS_IDX_PLL];
			OCS_SRC_PRI:                      return r[OCS_IDX_PRI];
			OCS_SRC_SOSC:                     return r[OCS_IDX_SOSC];
			OCS_SRC_LOW_POWER_RC_OSC:                     return r[OCS_IDX_LOW_POWER_RC_OSC];
			default:                          return r[OCS_IDX_FRC];
		endcase
	endfunction

	logic [7:0] frc_cnt_ff;
	logic [8:0] divn_wide;
	logic [7:0] divn_mask;
	logic       divn_tick;
	logic       div16_tick;
	logic       raw_tick;
	logic       tgt_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frc_cnt_ff <= 8'h00;
		end else if (pce && osc_rise[OCS_IDX_FRC]) begin
			frc_cnt_ff <= frc_cnt_ff + 8'h01;
		end
	end

	assign divn_wide  = (9'h002 << frcdiv_ff) - 9'h001;
	assign divn_mask  = divn_wide[7:0];
	assign divn_tick  = osc_rise[OCS_IDX_FRC] && ((frc_cnt_ff & divn_mask) == divn_mask);
	assign div16_tick = osc_rise[OCS_IDX_FRC] && (frc_cnt_ff[3:0] == 4'hF);

	always_comb begin
		case (cur_src_ff)
			OCS_SRC_FRC_DIVN:  raw_tick = divn_tick;
			OCS_SRC_FRC_DIV16: raw_tick = div16_tick;
			default:           raw_tick = base_rise(cur_src_ff, osc_rise);
		endcase
	end

	// A PLL source counts as ready only while the analog loop reports lock
	assign tgt_ready = (stable_cnt_ff == OCS_STABLE_EDGES) && (!is_pll(tgt_src_ff) || osc_lvl[OCS_IDX_LOCK]);

	////////////////////////////////////////////////////////////////////////////////
	// Source switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_src_ff    <= OCS_SRC_FRC;
			tgt_src_ff    <= OCS_SRC_FRC;
			sw_state_ff   <= OCS_SW_IDLE;
			stable_cnt_ff <= 4'h0;
		end else if (pce && strap_take) begin
			cur_src_ff    <= ocs_src_t'(strap_lvl[2:0]);
		end else if (pce) begin
			case (sw_state_ff)
				OCS_SW_IDLE: begin
					if (strap_done && switch_req_ff) begin
						tgt_src_ff    <= new_src_ff;
						stable_cnt_ff <= 4'h0;
						sw_state_ff   <= OCS_SW_WAIT;
					end
				end
				OCS_SW_WAIT: begin
					if (base_rise(tgt_src_ff, osc_rise) && stable_cnt_ff != OCS_STABLE_EDGES) begin
						stable_cnt_ff <= stable_cnt_ff + 4'h1;
					end
					// Swap only between ticks, so no tick is shortened
					if (tgt_ready && !raw_tick) begin
						sw_state_ff <= OCS_SW_SWAP;
					end
				end
				OCS_SW_SWAP: begin
					cur_src_ff  <= tgt_src_ff;
					sw_state_ff <= OCS_SW_IDLE;
				end
				default: begin
					sw_state_ff <= OCS_SW_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode number from the current source and the primary mode strap, 0 to 11
	logic [1:0] pm_ofs;

	// High-speed, crystal, external count up from the base; the reserved code folds onto high-speed
	assign pm_ofs = (pmode_ff == OCS_PM_NONE) ? 2'h0 : 2'h2 - 2'(pmode_ff);

	always_comb begin
		case (cur_src_ff)
			OCS_SRC_FRC_DIVN:  mode = 4'h0;
			OCS_SRC_FRC_DIV16: mode = 4'h1;
			OCS_SRC_LOW_POWER_RC_OSC:      mode = 4'h2;
			OCS_SRC_SOSC:      mode = 4'h3;
			OCS_SRC_PRI_PLL:   mode = 4'h4 + {2'h0, pm_ofs};
			OCS_SRC_PRI:       mode = 4'h7 + {2'h0, pm_ofs};
			OCS_SRC_FRC_PLL:   mode = 4'hA;
			default:           mode = 4'hB;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// PLL control and oscillator modes
	logic pll_tgt;
	logic pri_used;

	assign pll_tgt  = (sw_state_ff != OCS_SW_IDLE) && is_pll(tgt_src_ff);
	assign pri_used = is_pri(cur_src_ff) || ((sw_state_ff != OCS_SW_IDLE) && is_pri(tgt_src_ff));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_enable                 <= 1'b0;
			pll_from_primary           <= 1'b0;
			pll_n1                     <= OCS_N1_OFS;
			pll_m                      <= OCS_M_OFS;
			pll_n2                     <= 4'h2;
			crystal_mode_en            <= 1'b0;
			high_speed_crystal_mode_en <= 1'b0;
			external_clock_mode_en     <= 1'b0;
			secondary_osc_en           <= 1'b0;
		end else if (pce) begin
			pll_enable       <= is_pll(cur_src_ff) || pll_tgt;
			pll_from_primary <= pll_tgt ? (tgt_src_ff == OCS_SRC_PRI_PLL)
			                            : (cur_src_ff == OCS_SRC_PRI_PLL);
			pll_n1           <= {1'b0, pre_ff} + OCS_N1_OFS;
			pll_m            <= {1'b0, fb_ff} + OCS_M_OFS;
			case (post_ff)
				2'h0:    pll_n2 <= 4'h2;
				2'h1:    pll_n2 <= 4'h4;
				default: pll_n2 <= 4'h8;
			endcase
			crystal_mode_en            <= pri_used && (pmode_ff == OCS_PM_CRYSTAL);
			high_speed_crystal_mode_en <= pri_used && (pmode_ff == OCS_PM_HIGH_SPEED);
			external_clock_mode_en     <= pri_used && (pmode_ff == OCS_PM_EXTERNAL);
			secondary_osc_en           <= (cur_src_ff == OCS_SRC_SOSC) || (tgt_src_ff == OCS_SRC_SOSC);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock ticks
	logic       fp_phase_ff;
	logic [6:0] doze_cnt_ff;
	logic [7:0] doze_wide;
	logic [6:0] doze_mask;
	logic       fp_raw;
	logic       cpu_raw;

	assign doze_wide = (8'h01 << doze_ff) - 8'h01;
	assign doze_mask = doze_wide[6:0];
	assign fp_raw    = raw_tick && fp_phase_ff;
	assign cpu_raw   = fp_raw && (!dozen_ff || ((doze_cnt_ff & doze_mask) == doze_mask));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fp_phase_ff <= 1'b0;
			doze_cnt_ff <= 7'h00;
		end else if (pce) begin
			if (raw_tick) begin
				fp_phase_ff <= !fp_phase_ff;
			end
			if (fp_raw) begin
				doze_cnt_ff <= doze_cnt_ff + 7'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fosc_tick               <= 1'b0;
			peripheral_clock_tick   <= 1'b0;
			cpu_clock_tick          <= 1'b0;
			watchdog_timer_ref_tick <= 1'b0;
		end else if (pce) begin
			fosc_tick               <= raw_tick;
			peripheral_clock_tick   <= fp_raw;
			cpu_clock_tick          <= cpu_raw;
			watchdog_timer_ref_tick <= osc_rise[OCS_IDX_LOW_POWER_RC_OSC];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic fosc_seen_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fosc_seen_ff <= 1'b0;
		end else if (pce && fosc_tick) begin
			fosc_seen_ff <= !peripheral_clock_tick;
		end
	end

	property p_fp_half;
		peripheral_clock_tick |-> fosc_tick && fosc_seen_ff;
	endproperty
	a_fp_half: assert property (p_fp_half) else $error("peripheral tick not every second fosc tick");

	property p_no_doze_equal;
		$past(pce) && !$past(dozen_ff) |-> cpu_clock_tick == peripheral_clock_tick;
	endproperty
	a_no_doze_equal: assert property (p_no_doze_equal) else $error("cpu and peripheral ticks differ");

	property p_n1_decode;
		$past(pce) |-> pll_n1 == {1'b0, $past(pre_ff)} + 6'h02;
	endproperty
	a_n1_decode: assert property (p_n1_decode) else $error("prescale factor wrong");

	property p_m_decode;
		$past(pce) && $past(fb_ff) == 9'h01E |-> pll_m == 10'h020;
	endproperty
	a_m_decode: assert property (p_m_decode) else $error("feedback factor wrong");

	property p_n2_zero;
		$past(pce) && $past(post_ff) == 2'h0 |-> pll_n2 == 4'h2;
	endproperty
	a_n2_zero: assert property (p_n2_zero) else $error("postscale zero not two");

	property p_pll_source;
		pll_enable |-> $past(is_pll(cur_src_ff) || pll_tgt);
	endproperty
	a_pll_source: assert property (p_pll_source) else $error("PLL on without a PLL source");

	property p_low_power_rc_osc_ref;
		$past(pce) |-> watchdog_timer_ref_tick == $past(osc_rise[OCS_IDX_LOW_POWER_RC_OSC]);
	endproperty
	a_low_power_rc_osc_ref: assert property (p_low_power_rc_osc_ref) else $error("watchdog reference lost");

	property p_switch_safe;
		$past(strap_done) && $changed(cur_src_ff) |-> $past(sw_done) && $past(stable_cnt_ff, 2) == OCS_STABLE_EDGES;
	endproperty
	a_switch_safe: assert property (p_switch_safe) else $error("source changed before stable");

	property p_strap_load;
		pce && strap_take |=> cur_src_ff == ocs_src_t'($past(strap_lvl[2:0])) ##1 strap_done;
	endproperty
	a_strap_load: assert property (p_strap_load) else $error("strap source not taken");

	c_switch: cover property (sw_done);
	c_doze:   cover property (dozen_ff && peripheral_clock_tick && !cpu_clock_tick);
	c_slverr: cover property (pslverr);

endmodule

// ---- pkg/ocs_pkg.sv ----
// Constants, field layouts, reset values and state types of the oscillator and clock select block.
// Assumes a 32-bit APB slave at 200 MHz that samples every oscillator pin as a plain level.
package ocs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OCS_ADDR_CLOCK_DIVISOR = 8'h00;
	localparam logic [7:0] OCS_ADDR_PLL_FEEDBACK  = 8'h04;
	localparam logic [7:0] OCS_ADDR_OSC_CONTROL   = 8'h08;
	localparam logic [7:0] OCS_ADDR_PLL_FACTOR    = 8'h0C;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int OCS_CD_ROI        = 15;
	localparam int OCS_CD_DOZE_LSB   = 12;
	localparam int OCS_CD_DOZEN      = 11;
	localparam int OCS_CD_FRCDIV_LSB = 8;
	localparam int OCS_CD_POST_LSB   = 6;
	localparam int OCS_CD_PRE_LSB    = 0;
	localparam int OCS_OC_CUR_LSB    = 12;
	localparam int OCS_OC_NEW_LSB    = 8;
	localparam int OCS_OC_LOCK       = 5;
	localparam int OCS_OC_SWITCH     = 0;
	localparam int OCS_PF_N1_LSB     = 0;
	localparam int OCS_PF_N2_LSB     = 8;
	localparam int OCS_PF_M_LSB      = 16;
	localparam int OCS_PF_MODE_LSB   = 28;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and decode offsets
	localparam logic [2:0] OCS_RST_DOZE   = 3'h3;
	localparam logic [2:0] OCS_RST_FRCDIV = 3'h0;
	localparam logic [1:0] OCS_RST_POST   = 2'h1;
	localparam logic [4:0] OCS_RST_PRE    = 5'h00;
	localparam logic [8:0] OCS_RST_FB     = 9'h030;
	localparam logic [5:0] OCS_N1_OFS     = 6'h02;
	localparam logic [9:0] OCS_M_OFS      = 10'h002;

	////////////////////////////////////////////////////////////////////////////////
	// Counts of cycles or edges
	localparam logic [3:0] OCS_STABLE_EDGES = 4'h4;
	localparam logic [1:0] OCS_STRAP_TAKE   = 2'h2;
	localparam logic [1:0] OCS_STRAP_DONE   = 2'h3;

	// Bit positions in the synchronised oscillator vector
	localparam int OCS_IDX_FRC  = 0;
	localparam int OCS_IDX_PRI  = 1;
	localparam int OCS_IDX_SOSC = 2;
	localparam int OCS_IDX_LOW_POWER_RC_OSC = 3;
	localparam int OCS_IDX_PLL  = 4;
	localparam int OCS_IDX_LOCK = 5;
	localparam int OCS_NUM_OSC  = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		OCS_SRC_FRC       = 3'b000,
		OCS_SRC_FRC_PLL   = 3'b001,
		OCS_SRC_PRI       = 3'b010,
		OCS_SRC_PRI_PLL   = 3'b011,
		OCS_SRC_SOSC      = 3'b100,
		OCS_SRC_LOW_POWER_RC_OSC      = 3'b101,
		OCS_SRC_FRC_DIV16 = 3'b110,
		OCS_SRC_FRC_DIVN  = 3'b111
	} ocs_src_t;

	typedef enum logic [1:0] {
		OCS_PM_EXTERNAL   = 2'b00,
		OCS_PM_CRYSTAL    = 2'b01,
		OCS_PM_HIGH_SPEED = 2'b10,
		OCS_PM_NONE       = 2'b11
	} ocs_pmode_t;

	typedef enum logic [1:0] {
		OCS_SW_IDLE = 2'b00,
		OCS_SW_WAIT = 2'b01,
		OCS_SW_SWAP = 2'b10
	} ocs_sw_state_t;

endpackage

// ---- design/ocs_sync.sv ----
// Two-flop synchroniser with rising-edge detect for a vector of slow pins.
// Assumes each bit is a level that stays for at least two pclk periods.
`timescale 1ns/10ps
module ocs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             pce,
	// Pins and results
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out,
	output logic      [WIDTH-1:0] rise_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;

	// The first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else if (pce) begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign sync_out = sync_ff;
	assign rise_out = sync_ff & ~prev_ff;

endmodule

// ---- test/tb.sv ----
// Self-checking bench for the oscillator and clock select block, driven over APB.
// Assumes ocs_pkg is compiled first; oscillator pins come from one free-running counter.
`timescale 1ns/10ps
module tb;
	import ocs_pkg::*;
	logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, err, irq_pending, pll_lock_in;
	logic        fast_rc_osc_in, primary_osc_in, secondary_crystal_osc_in, low_power_rc_osc_in, pll_clk_in;
	logic        pll_enable, pll_from_primary, crystal_mode_en, fosc_tick, peripheral_clock_tick;
	logic        cpu_clock_tick, watchdog_timer_ref_tick;
	logic [2:0]  initial_source_select, code;
	logic [1:0]  primary_mode_select, post;
	logic [3:0]  n2;
	logic [4:0]  pre;
	logic [7:0]  paddr, cnt;
	logic [8:0]  fb;
	logic [9:0]  pll_m;
	logic [31:0] pwdata, prdata, rd;
	int          n_fail, total_checks, n[4], s[4];
	localparam logic [3:0]  MODE_OF [0:7] = '{4'hB, 4'hA, 4'h8, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
	// Decode-only corners; no analog loop here, so frequency ranges are not exercised
	localparam logic [15:0] FAC [0:3] = '{{5'h00, 2'h0, 9'h01E}, {5'h1F, 2'h1, 9'h000}, {5'h05, 2'h2, 9'h1FF},
		{5'h01, 2'h3, 9'h002}};

	ocs_clock_ctrl ocs_clock_ctrl_inst (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .fast_rc_osc_in, .primary_osc_in, .secondary_crystal_osc_in, .low_power_rc_osc_in,
		.pll_clk_in, .pll_lock_in, .initial_source_select, .primary_mode_select, .irq_pending, .pll_enable,
		.pll_from_primary, .pll_n1(), .pll_m, .pll_n2(), .crystal_mode_en, .high_speed_crystal_mode_en(),
		.external_clock_mode_en(), .secondary_osc_en(), .fosc_tick, .peripheral_clock_tick, .cpu_clock_tick,
		.watchdog_timer_ref_tick);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Pin periods are powers of two so a 256-cycle window holds whole periods
	always @(posedge pclk) begin
		cnt <= cnt + 8'h01;
		{fast_rc_osc_in, pll_clk_in, primary_osc_in} <= {cnt[2], cnt[1], cnt[3]};
		{low_power_rc_osc_in, secondary_crystal_osc_in} <= {cnt[4], cnt[5]};
		n <= '{n[0] + fosc_tick, n[1] + peripheral_clock_tick, n[2] + cpu_clock_tick, n[3] + watchdog_timer_ref_tick};
	end

	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_fail++;
			finish_test();
		end
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask

	// Settle first: a divider change may leave one odd period behind it
	task automatic window(input int e [4]);
		repeat (64) @(posedge pclk);
		s = n;
		repeat (256) @(posedge pclk);
		for (int k = 0; k < 4; k++) chk(n[k] - s[k], e[k]);
	endtask

	task automatic switch_to(input logic [2:0] c);
		int i;
		xfer(1'b1, OCS_ADDR_OSC_CONTROL, {21'h0, c, 8'h01});
		i = 0;
		do begin
			xfer(1'b0, OCS_ADDR_OSC_CONTROL, 32'h0);
			i++;
		end while (rd[0] !== 1'b0 && i < 1000);
		if (i >= 1000) begin
			n_fail++;
			finish_test();
		end
		chk({29'h0, rd[14:12]}, {29'h0, c});
	endtask

	////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cnt, irq_pending} = '0;
		{fast_rc_osc_in, primary_osc_in, secondary_crystal_osc_in, low_power_rc_osc_in, pll_clk_in} = '0;
		{pce, pll_lock_in, initial_source_select, primary_mode_select} = {2'b11, 3'h7, 2'h1};
		n = '{default: 0};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		xfer(1'b0, OCS_ADDR_CLOCK_DIVISOR, 32'h0);
		chk(rd, 32'h0000_3040);
		xfer(1'b0, OCS_ADDR_PLL_FEEDBACK, 32'h0);
		chk(rd, 32'h0000_0030);
		xfer(1'b0, OCS_ADDR_OSC_CONTROL, 32'h0);
		chk(rd & 32'hFFFF_FFDF, 32'h0000_7700);
		xfer(1'b0, OCS_ADDR_PLL_FACTOR, 32'h0);
		chk(rd, 32'h0032_0402);
		xfer(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], err}, 32'h0000_0001);
		window('{16, 8, 8, 8});
		xfer(1'b1, OCS_ADDR_CLOCK_DIVISOR, 32'h0000_3140);
		window('{8, 4, 4, 8});
		for (int c = 6; c >= 0; c--) begin
			code = 3'(c);
			switch_to(code);
			xfer(1'b0, OCS_ADDR_PLL_FACTOR, 32'h0);
			chk({28'h0, rd[31:28]}, {28'h0, MODE_OF[code]});
			chk({30'h0, pll_enable, crystal_mode_en}, {30'h0, code == 3'h1 || code == 3'h3, code[2:1] == 2'h1});
			if (code[1:0] == 2'h1 || code == 3'h3) chk({31'h0, pll_from_primary}, {31'h0, code == 3'h3});
		end
		window('{32, 16, 16, 8});
		xfer(1'b1, OCS_ADDR_CLOCK_DIVISOR, 32'h0000_1940);
		window('{32, 16, 8, 8});
		xfer(1'b1, OCS_ADDR_CLOCK_DIVISOR, 32'h0000_9940);
		irq_pending <= 1'b1;
		@(posedge pclk);
		irq_pending <= 1'b0;
		xfer(1'b0, OCS_ADDR_CLOCK_DIVISOR, 32'h0);
		chk(rd, 32'h0000_9140);
		for (int k = 0; k < 4; k++) begin
			{pre, post, fb} = FAC[k];
			n2 = (post == 2'h0) ? 4'h2 : (post == 2'h1) ? 4'h4 : 4'h8;
			xfer(1'b1, OCS_ADDR_PLL_FEEDBACK, {23'h0, fb});
			xfer(1'b1, OCS_ADDR_CLOCK_DIVISOR, {24'h0, post, 1'b0, pre});
			xfer(1'b0, OCS_ADDR_PLL_FACTOR, 32'h0);
			chk(rd, {4'hB, 2'h0, {1'b0, fb} + 10'h002, 4'h0, n2, 2'h0, {1'b0, pre} + 6'h02});
			chk({22'h0, pll_m}, {22'h0, {1'b0, fb} + 10'h002});
		end
		finish_test();
	end
endmodule
